// File: pkg/line_audio_route_pkg.sv
// constants, types and register map for the line and audio relay router
package line_audio_route_pkg;

    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_AUDIO     = 8'h04;
    localparam logic [7:0]  ADDR_SPK       = 8'h08;
    localparam logic [7:0]  ADDR_STATUS    = 8'h0c;

    localparam logic [7:0]  CLASS_DATA     = 8'h00;
    localparam logic [7:0]  CLASS_FAX      = 8'h01;
    localparam logic [7:0]  CLASS_VOICE    = 8'h08;
    localparam logic [7:0]  FAX_CLASS_SETTING_ALT     = 8'h50;
    localparam logic [15:0] RATE_7200      = 16'h1c20;
    localparam logic [15:0] RATE_11025     = 16'h2b11;
    localparam logic [3:0]  BPS_2          = 4'h2;
    localparam logic [3:0]  BPS_4          = 4'h4;
    localparam logic [3:0]  BPS_8          = 4'h8;

    // ctrl field positions
    localparam int CTRL_CLASS_LSB  = 0;
    localparam int CTRL_FAX_CLASS_SETTING_LSB = 8;
    localparam int CTRL_VLS_LSB    = 16;
    localparam int CTRL_THREE_BIT  = 20;
    localparam int CTRL_EC_BIT     = 21;
    // audio field positions
    localparam int AUD_RATE_LSB    = 0;
    localparam int AUD_BPS_LSB     = 16;
    localparam int AUD_STAGE_LSB   = 20;
    // speaker field positions
    localparam int SPK_MGAIN_LSB   = 0;
    localparam int SPK_MMUTE_BIT   = 8;
    localparam int SPK_VOL_LSB     = 16;
    localparam int SPK_SMUTE_BIT   = 24;

    // reset values
    localparam logic [7:0]  RST_CLASS  = CLASS_DATA;
    localparam logic [7:0]  RST_FAX_CLASS_SETTING = 8'h00;
    localparam logic [15:0] RST_RATE   = RATE_7200;
    localparam logic [3:0]  RST_BPS    = BPS_4;
    localparam logic [7:0]  RST_GAIN   = 8'h80;

    // input select bits: line rx, handset mic, voice mic, sound source
    localparam logic [3:0] IN_RX  = 4'h1;
    localparam logic [3:0] IN_HS  = 4'h2;
    localparam logic [3:0] IN_MIC = 4'h4;
    localparam logic [3:0] IN_SND = 4'h8;
    // output enable bits: line tx, local speaker, handset speaker
    localparam logic [2:0] OUT_TX  = 3'h1;
    localparam logic [2:0] OUT_SPK = 3'h2;
    localparam logic [2:0] OUT_HS  = 3'h4;

    // pseudo-duplex hold after instability clears
    localparam int CLK_PERIOD_NS     = 100;
    localparam int RECOVER_TIME_NS   = 100000;
    localparam int RECOVER_CYCLES    = (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        STAGE_ON_HOOK  = 2'b00,
        STAGE_TONE_ON  = 2'b01,
        STAGE_TONE_OFF = 2'b10,
        STAGE_OFF_HOOK = 2'b11
    } alt_stage_type;

    typedef enum logic {
        DUPLEX_FULL   = 1'b0,
        DUPLEX_PSEUDO = 1'b1
    } duplex_type;

    // active-high relay requests plus routing
    typedef struct packed {
        logic       hold;
        logic       keep_hook;
        logic       offhook;
        logic       voice;
        logic       callerid;
        logic [3:0] in_sel;
        logic [2:0] out_sel;
    } route_type;

endpackage : line_audio_route_pkg

// File: core/line_audio_route_relay_ctrl.sv
// line select, relay drive and mode decode with an apb register file
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module line_audio_route_relay_ctrl
    import line_audio_route_pkg::*;
#(
    parameter int RECOVER_LEN = RECOVER_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // echo canceller health
    input  wire logic        echo_unstable,
    // line relays, active low
    output logic             offhook_relay_n,
    output logic             voice_relay_n,
    output logic             callerid_relay_n,
    // analog routing
    output logic [3:0]       input_select,
    output logic [2:0]       output_select,
    // operating modes
    output logic             voice_mode_en,
    output logic             audio_mode_en,
    output logic             full_duplex_speakerphone,
    output logic             pseudo_duplex,
    output logic             data_mode_en,
    output logic             fax_mode_en,
    output logic             alt_voice_data_en,
    output logic             cellular_ec_enable,
    // speakerphone controls
    output logic [7:0]       mic_gain,
    output logic             mic_mute,
    output logic [7:0]       speaker_volume,
    output logic             speaker_mute
);

    if (RECOVER_LEN < 1 || RECOVER_LEN > 65535) begin : g_chk
        $error("RECOVER_LEN out of range");
    end

    function automatic route_type vls_lookup(input logic [3:0] code, input logic three);
        route_type r;
        r = '{hold: 1'b0, keep_hook: 1'b0, offhook: 1'b0, voice: 1'b0,
              callerid: 1'b0, in_sel: 4'h0, out_sel: 3'h0};
        unique case (code)
            4'h0: begin
                r.offhook = 1'b1;
                r.in_sel  = IN_RX;
                r.out_sel = OUT_TX;
            end
            4'h1: begin
                r.voice    = 1'b1;
                r.callerid = three;
                r.in_sel   = IN_HS;
                r.out_sel  = OUT_HS;
            end
            4'h2: begin
                r.callerid = three;
                r.in_sel   = IN_RX;
                r.out_sel  = OUT_TX | OUT_SPK;
            end
            4'h3: begin
                r.voice    = 1'b1;
                r.callerid = three;
                r.in_sel   = IN_MIC;
                r.out_sel  = OUT_TX;
            end
            4'h4: begin
                r.offhook = 1'b1;
                r.in_sel  = IN_RX;
                r.out_sel = OUT_TX | OUT_SPK;
            end
            4'h6: begin
                r.offhook = 1'b1;
                r.in_sel  = IN_RX | IN_MIC;
                r.out_sel = OUT_TX | OUT_SPK;
            end
            4'h7: begin
                r.keep_hook = 1'b1;
                r.voice     = 1'b1;
                r.in_sel    = IN_SND;
                r.out_sel   = OUT_TX | OUT_SPK;
            end
            4'h8: begin
                r.keep_hook = 1'b1;
                r.callerid  = three;
                r.in_sel    = IN_RX;
                r.out_sel   = OUT_SPK;
            end
            4'h9: begin
                r.voice    = 1'b1;
                r.callerid = 1'b1;
                r.in_sel   = three ? (IN_RX | IN_SND) : (IN_HS | IN_MIC);
                r.out_sel  = OUT_HS | OUT_SPK;
            end
            default: begin
                r.hold = 1'b1;
            end
        endcase
        return r;
    endfunction : vls_lookup

    // registers written by software
    logic [7:0]    op_class_q;
    logic [7:0]    fax_class_q;
    logic [3:0]    vls_q;
    logic          three_q;
    logic          ec_q;
    logic [15:0]   rate_q;
    logic [3:0]    bps_q;
    alt_stage_type stage_q;
    logic [7:0]    mgain_q;
    logic          mmute_q;
    logic [7:0]    svol_q;
    logic          smute_q;
    // block state
    logic          oh_q;
    logic          vc_q;
    logic          cid_q;
    logic          oh_n_q, vc_n_q, cid_n_q;
    logic [3:0]    in_q;
    logic [2:0]    out_q;
    logic          voice_en_q;
    logic          audio_en_q;
    logic          full_duplex_speakerphone_q;
    logic          pseudo_q;
    logic          data_en_q;
    logic          fax_en_q;
    logic          alt_en_q;
    duplex_type    duplex_q;
    logic [15:0]   recover_q;
    logic          pready_q;
    logic [31:0]   prdata_q;
    logic          pslverr_q;

    // apb decode
    wire           apb_access = psel & penable & ~pready_q;
    wire           apb_wr     = psel & penable & pready_q & pwrite;
    wire           hit_ctrl   = (paddr == ADDR_CTRL);
    wire           hit_audio  = (paddr == ADDR_AUDIO);
    wire           hit_spk    = (paddr == ADDR_SPK);
    wire           hit_stat   = (paddr == ADDR_STATUS);
    wire           mapped     = hit_ctrl | hit_audio | hit_spk | hit_stat;
    wire           ro_write   = hit_stat & pwrite;
    wire           wr_ctrl    = apb_wr & hit_ctrl;
    wire           wr_audio   = apb_wr & hit_audio;
    wire           wr_spk     = apb_wr & hit_spk;

    wire [31:0]    rd_ctrl    = {10'h000, ec_q, three_q, vls_q, fax_class_q, op_class_q};
    wire [31:0]    rd_audio   = {10'h000, stage_q, bps_q, rate_q};
    wire [31:0]    rd_spk     = {7'h00, smute_q, svol_q, 7'h00, mmute_q, mgain_q};
    wire [31:0]    rd_stat    = {14'h0000, ec_q, out_q, in_q, cid_q, vc_q, oh_q,
                                 pseudo_q, alt_en_q, fax_en_q, data_en_q, full_duplex_speakerphone_q,
                                 audio_en_q, voice_en_q};
    wire [31:0]    rd_mux     = hit_ctrl  ? rd_ctrl  :
                                hit_audio ? rd_audio :
                                hit_spk   ? rd_spk   :
                                hit_stat  ? rd_stat  : 32'h0000_0000;

    // mode decode
    wire           cls_voice  = (op_class_q == CLASS_VOICE);
    wire           is_alt     = (fax_class_q == FAX_CLASS_SETTING_ALT);
    wire           voice_d    = cls_voice & (rate_q == RATE_7200)
                                & ((bps_q == BPS_2) | (bps_q == BPS_4));
    wire           audio_d    = cls_voice & (bps_q == BPS_8)
                                & ((rate_q == RATE_7200) | (rate_q == RATE_11025));
    wire           full_duplex_speakerphone_d     = cls_voice & (vls_q == 4'h6);
    wire           data_d     = (fax_class_q == CLASS_DATA);
    wire           fax_d      = (fax_class_q == CLASS_FAX) | (op_class_q == CLASS_FAX);

    wire route_type vls_rt    = vls_lookup(vls_q, three_q);

    // alternating voice-data stage relays
    wire           alt_oh     = (stage_q == STAGE_TONE_OFF) | (stage_q == STAGE_OFF_HOOK);
    wire           alt_vc     = (stage_q == STAGE_OFF_HOOK);
    wire           alt_cid    = three_q & ((stage_q == STAGE_TONE_ON)
                                | (stage_q == STAGE_TONE_OFF));

    wire           vls_apply  = cls_voice & ~vls_rt.hold;
    wire           alt_apply  = ~cls_voice & is_alt;
    // codes 7 and 8 keep whatever off-hook state the host set up earlier
    wire           oh_d       = vls_apply ? (vls_rt.keep_hook ? oh_q : vls_rt.offhook) :
                                alt_apply ? alt_oh : oh_q;
    wire           vc_d       = vls_apply ? vls_rt.voice    : alt_apply ? alt_vc  : vc_q;
    wire           cid_d      = vls_apply ? vls_rt.callerid : alt_apply ? alt_cid : cid_q;
    wire [3:0]     in_d       = vls_apply ? vls_rt.in_sel  : in_q;
    wire [2:0]     out_d      = vls_apply ? vls_rt.out_sel : out_q;

    // apb handshake, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= apb_access;
            prdata_q  <= (apb_access & ~pwrite) ? rd_mux : 32'h0000_0000;
            pslverr_q <= apb_access & (~mapped | ro_write);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_class_q  <= RST_CLASS;
            fax_class_q <= RST_FAX_CLASS_SETTING;
            vls_q       <= 4'h0;
            three_q     <= 1'b0;
            ec_q        <= 1'b0;
        end else if (wr_ctrl) begin
            op_class_q  <= pwdata[CTRL_CLASS_LSB +: 8];
            fax_class_q <= pwdata[CTRL_FAX_CLASS_SETTING_LSB +: 8];
            vls_q       <= pwdata[CTRL_VLS_LSB +: 4];
            three_q     <= pwdata[CTRL_THREE_BIT];
            ec_q        <= pwdata[CTRL_EC_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_q  <= RST_RATE;
            bps_q   <= RST_BPS;
            stage_q <= STAGE_ON_HOOK;
        end else if (wr_audio) begin
            rate_q  <= pwdata[AUD_RATE_LSB +: 16];
            bps_q   <= pwdata[AUD_BPS_LSB +: 4];
            stage_q <= alt_stage_type'(pwdata[AUD_STAGE_LSB +: 2]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mgain_q <= RST_GAIN;
            mmute_q <= 1'b0;
            svol_q  <= RST_GAIN;
            smute_q <= 1'b0;
        end else if (wr_spk) begin
            mgain_q <= pwdata[SPK_MGAIN_LSB +: 8];
            mmute_q <= pwdata[SPK_MMUTE_BIT];
            svol_q  <= pwdata[SPK_VOL_LSB +: 8];
            smute_q <= pwdata[SPK_SMUTE_BIT];
        end
    end

    // relay and routing state, all released at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oh_q  <= 1'b0;
            vc_q  <= 1'b0;
            cid_q <= 1'b0;
            in_q  <= 4'h0;
            out_q <= 3'h0;
            oh_n_q  <= 1'b1;
            vc_n_q  <= 1'b1;
            cid_n_q <= 1'b1;
        end else begin
            oh_q  <= oh_d;
            vc_q  <= vc_d;
            cid_q <= cid_d;
            oh_n_q  <= ~oh_d;
            vc_n_q  <= ~vc_d;
            cid_n_q <= ~cid_d;
            in_q  <= in_d;
            out_q <= out_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            voice_en_q <= 1'b0;
            audio_en_q <= 1'b0;
            data_en_q  <= 1'b0;
            fax_en_q   <= 1'b0;
            alt_en_q   <= 1'b0;
        end else begin
            voice_en_q <= voice_d;
            audio_en_q <= audio_d;
            data_en_q  <= data_d;
            fax_en_q   <= fax_d;
            alt_en_q   <= is_alt;
        end
    end

    // duplex fallback; returns to full duplex after a quiet hold time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duplex_q  <= DUPLEX_FULL;
            recover_q <= 16'h0000;
        end else if (!full_duplex_speakerphone_d) begin
            duplex_q  <= DUPLEX_FULL;
            recover_q <= 16'h0000;
        end else if (echo_unstable) begin
            duplex_q  <= DUPLEX_PSEUDO;
            recover_q <= 16'(RECOVER_LEN);
        end else if (duplex_q == DUPLEX_PSEUDO) begin
            if (recover_q <= 16'h0001) begin
                duplex_q <= DUPLEX_FULL;
            end
            recover_q <= (recover_q == 16'h0000) ? 16'h0000 : recover_q - 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_duplex_speakerphone_q   <= 1'b0;
            pseudo_q <= 1'b0;
        end else begin
            full_duplex_speakerphone_q   <= full_duplex_speakerphone_d & (duplex_q == DUPLEX_FULL) & ~echo_unstable;
            pseudo_q <= full_duplex_speakerphone_d & ((duplex_q == DUPLEX_PSEUDO) | echo_unstable);
        end
    end

    assign pready                   = pready_q;
    assign prdata                   = prdata_q;
    assign pslverr                  = pslverr_q;
    assign offhook_relay_n          = oh_n_q;
    assign voice_relay_n            = vc_n_q;
    assign callerid_relay_n         = cid_n_q;
    assign input_select             = in_q;
    assign output_select            = out_q;
    assign voice_mode_en            = voice_en_q;
    assign audio_mode_en            = audio_en_q;
    assign full_duplex_speakerphone = full_duplex_speakerphone_q;
    assign pseudo_duplex            = pseudo_q;
    assign data_mode_en             = data_en_q;
    assign fax_mode_en              = fax_en_q;
    assign alt_voice_data_en        = alt_en_q;
    assign cellular_ec_enable       = ec_q;
    assign mic_gain                 = mgain_q;
    assign mic_mute                 = mmute_q;
    assign speaker_volume           = svol_q;
    assign speaker_mute             = smute_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_VLS0_ROUTE: assert property (
        (cls_voice && vls_q == 4'h0) |=> (!offhook_relay_n && voice_relay_n
            && callerid_relay_n && input_select == IN_RX && output_select == OUT_TX))
        else $error("code 0 routing wrong");

    AST_VLS1_THREE: assert property (
        (cls_voice && vls_q == 4'h1 && three_q) |=> (offhook_relay_n
            && !voice_relay_n && !callerid_relay_n && output_select == OUT_HS))
        else $error("code 1 relays wrong");

    AST_VLS5_HOLD: assert property (
        (cls_voice && vls_q == 4'h5) |=> ($stable(offhook_relay_n)
            && $stable(voice_relay_n) && $stable(callerid_relay_n) && $stable(input_select)))
        else $error("reserved code changed relays");

    AST_VLS7_KEEP: assert property (
        (cls_voice && vls_q == 4'h7) |=> (offhook_relay_n == $past(offhook_relay_n)
            && !voice_relay_n && callerid_relay_n && input_select == IN_SND))
        else $error("code 7 relays wrong");

    AST_VLS9_INPUT: assert property (
        (cls_voice && vls_q == 4'h9) |=> (input_select ==
            ($past(three_q) ? (IN_RX | IN_SND) : (IN_HS | IN_MIC)) && !callerid_relay_n))
        else $error("code 9 inputs wrong");

    AST_CLASS_GATE: assert property (
        (!cls_voice && !is_alt) |=> ($stable(offhook_relay_n) && $stable(output_select)))
        else $error("routing moved outside voice class");

    AST_ALT_STAGE: assert property (
        (!cls_voice && is_alt && stage_q == STAGE_TONE_ON) |=> (offhook_relay_n
            && voice_relay_n && (callerid_relay_n == !$past(three_q))))
        else $error("tone stage relays wrong");

    AST_ALT_OFFHOOK: assert property (
        (!cls_voice && is_alt && stage_q == STAGE_OFF_HOOK) |=> (!offhook_relay_n
            && !voice_relay_n && callerid_relay_n))
        else $error("stage 3 relays wrong");

    AST_VOICE_EN: assert property (
        (cls_voice && rate_q == RATE_7200 && bps_q == BPS_4) |=> voice_mode_en)
        else $error("voice mode not enabled");

    AST_FALLBACK: assert property (
        (full_duplex_speakerphone_d && echo_unstable) |=> (pseudo_duplex && !full_duplex_speakerphone))
        else $error("no duplex fallback");

    AST_APB_WAIT: assert property (
        (psel && penable && !pready) |=> pready)
        else $error("apb answer late");

endmodule : line_audio_route_relay_ctrl

// File: testbench/host_fw_model.sv
// host firmware model: apb master that sets the mode codes
`timescale 1ns/1ps
module host_fw_model (
    // clock
    input  wire logic        pclk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // one transfer: setup, access held until pready, then release
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : host_fw_model

// File: testbench/test_line_audio_route_relay_ctrl.sv
// self-checking bench for the line and audio relay router
`timescale 1ns/1ps
module test_line_audio_route_relay_ctrl
    import line_audio_route_pkg::*;
;
    logic        pclk, presetn, echo_unstable, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr, mic_gain, speaker_volume;
    logic [31:0] pwdata, prdata, rdat;
    logic        offhook_relay_n, voice_relay_n, callerid_relay_n, mic_mute, speaker_mute;
    logic [3:0]  input_select;
    logic [2:0]  output_select;
    logic        voice_mode_en, audio_mode_en, full_duplex_speakerphone, pseudo_duplex;
    logic        data_mode_en, fax_mode_en, alt_voice_data_en, cellular_ec_enable;
    int          err_count, n_tests;
    // rows: three bit, code, inputs, outputs, {offhook_n, voice_n, callerid_n}
    logic [14:0] rows [18] = '{
        {1'b0,4'h0,IN_RX,OUT_TX,3'b011}, {1'b0,4'h1,IN_HS,OUT_HS,3'b101},
        {1'b0,4'h2,IN_RX,OUT_TX|OUT_SPK,3'b111}, {1'b0,4'h3,IN_MIC,OUT_TX,3'b101},
        {1'b0,4'h4,IN_RX,OUT_TX|OUT_SPK,3'b011}, {1'b0,4'h6,IN_RX|IN_MIC,OUT_TX|OUT_SPK,3'b011},
        {1'b0,4'h7,IN_SND,OUT_TX|OUT_SPK,3'b001}, {1'b0,4'h8,IN_RX,OUT_SPK,3'b011},
        {1'b0,4'h9,IN_HS|IN_MIC,OUT_HS|OUT_SPK,3'b100}, {1'b1,4'h0,IN_RX,OUT_TX,3'b011},
        {1'b1,4'h1,IN_HS,OUT_HS,3'b100}, {1'b1,4'h2,IN_RX,OUT_TX|OUT_SPK,3'b110},
        {1'b1,4'h3,IN_MIC,OUT_TX,3'b100}, {1'b1,4'h6,IN_RX|IN_MIC,OUT_TX|OUT_SPK,3'b011},
        {1'b1,4'h7,IN_SND,OUT_TX|OUT_SPK,3'b001}, {1'b1,4'h8,IN_RX,OUT_SPK,3'b010},
        {1'b1,4'h9,IN_RX|IN_SND,OUT_HS|OUT_SPK,3'b100}, {1'b1,4'h4,IN_RX,OUT_TX|OUT_SPK,3'b011}};

    host_fw_model i_host_fw_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    line_audio_route_relay_ctrl #(.RECOVER_LEN(4)) i_line_audio_route_relay_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .echo_unstable(echo_unstable), .offhook_relay_n(offhook_relay_n),
        .voice_relay_n(voice_relay_n), .callerid_relay_n(callerid_relay_n),
        .input_select(input_select), .output_select(output_select),
        .voice_mode_en(voice_mode_en), .audio_mode_en(audio_mode_en),
        .full_duplex_speakerphone(full_duplex_speakerphone), .pseudo_duplex(pseudo_duplex),
        .data_mode_en(data_mode_en), .fax_mode_en(fax_mode_en),
        .alt_voice_data_en(alt_voice_data_en), .cellular_ec_enable(cellular_ec_enable),
        .mic_gain(mic_gain), .mic_mute(mic_mute), .speaker_volume(speaker_volume),
        .speaker_mute(speaker_mute));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function automatic logic [9:0] route();
        return {input_select, output_select, offhook_relay_n, voice_relay_n, callerid_relay_n};
    endfunction : route

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host_fw_model.xfer(1'b1, a, d, rdat, rerr);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        i_host_fw_model.xfer(1'b0, a, 32'h0, rdat, rerr);
        chk(rdat, exp, "read data");
        chk(rerr, 1'b0, "read error");
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    task automatic tally_and_finish;
        $display("mismatches %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        err_count = 0;
        n_tests = 0;
        presetn = 1'b0;
        echo_unstable = 1'b0;
        repeat (20) @(posedge pclk);
        chk(route(), 10'h007, "reset relays");
        chk({mic_gain, speaker_volume}, {RST_GAIN, RST_GAIN}, "reset gains");
        chk({mic_mute, speaker_mute, pready}, 3'b000, "reset flags");
        presetn <= 1'b1;
        settle();
        chk(data_mode_en, 1'b1, "data mode");
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_AUDIO, {12'h0, RST_BPS, RST_RATE});
        rd(ADDR_SPK, {8'h0, RST_GAIN, 8'h0, RST_GAIN});
        // code 7 and 8 rows follow a row with off-hook on
        foreach (rows[i]) begin
            wr(ADDR_CTRL, {11'h0, rows[i][14:10], 8'h00, CLASS_VOICE});
            settle();
            chk(route(), rows[i][9:0], "row");
        end
        wr(ADDR_CTRL, {11'h0, 1'b1, 4'h5, 8'h00, CLASS_VOICE});
        settle();
        chk(route(), rows[17][9:0], "reserved code");
        wr(ADDR_CTRL, {11'h0, 1'b0, 4'h1, 8'h00, CLASS_DATA});
        settle();
        chk(route(), rows[17][9:0], "class not voice");
        for (int t = 0; t < 2; t++) begin
            wr(ADDR_CTRL, {11'h0, t[0], 4'h0, FAX_CLASS_SETTING_ALT, CLASS_DATA});
            for (int s = 0; s < 4; s++) begin
                wr(ADDR_AUDIO, {10'h0, s[1:0], BPS_4, RATE_7200});
                settle();
                chk(route(), {rows[17][9:3], s < 2, s != 3, !(t == 1 && (s == 1 || s == 2))},
                    "stage");
            end
        end
        chk(alt_voice_data_en, 1'b1, "alternating mode");
        wr(ADDR_CTRL, {11'h0, 1'b0, 4'h6, 8'h00, CLASS_VOICE});
        wr(ADDR_AUDIO, {12'h0, BPS_2, RATE_7200});
        settle();
        chk({voice_mode_en, audio_mode_en}, 2'b10, "voice");
        chk(full_duplex_speakerphone, 1'b1, "speakerphone");
        wr(ADDR_AUDIO, {12'h0, BPS_8, RATE_11025});
        settle();
        chk({voice_mode_en, audio_mode_en}, 2'b01, "audio");
        chk(full_duplex_speakerphone, 1'b1, "speakerphone");
        wr(ADDR_AUDIO, {12'h0, BPS_8, 16'h1f40});
        settle();
        chk({voice_mode_en, audio_mode_en}, 2'b00, "bad rate");
        @(posedge pclk);
        echo_unstable <= 1'b1;
        settle();
        chk({pseudo_duplex, full_duplex_speakerphone}, 2'b10, "fallback");
        @(posedge pclk);
        echo_unstable <= 1'b0;
        settle();
        chk(pseudo_duplex, 1'b1, "duplex hold");
        repeat (10) @(posedge pclk);
        @(negedge pclk);
        chk({pseudo_duplex, full_duplex_speakerphone}, 2'b01, "recover");
        wr(ADDR_SPK, {7'h0, 1'b1, 8'h5a, 7'h0, 1'b1, 8'h3c});
        settle();
        chk({mic_gain, mic_mute, speaker_volume, speaker_mute}, {8'h3c, 1'b1, 8'h5a, 1'b1},
            "spk");
        wr(ADDR_CTRL, {10'h0, 1'b1, 1'b0, 4'h0, 8'h00, CLASS_FAX});
        settle();
        chk({fax_mode_en, data_mode_en, cellular_ec_enable}, 3'b111, "fax op");
        wr(ADDR_CTRL, {16'h0, 8'h01, CLASS_DATA});
        settle();
        chk({fax_mode_en, data_mode_en, cellular_ec_enable}, 3'b100, "fax_class_setting");
        i_host_fw_model.xfer(1'b0, 8'h10, 32'h0, rdat, rerr);
        chk(rerr, 1'b1, "unmapped");
        wr(ADDR_STATUS, 32'hffff_ffff);
        chk(rerr, 1'b1, "status write");
        rd(ADDR_CTRL, {16'h0, 8'h01, CLASS_DATA});
        rd(ADDR_STATUS, {15'h0, OUT_TX|OUT_SPK, IN_RX|IN_MIC, 3'b001, 7'h10});
        // reset in mid-run while the off-hook relay is held
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk(route(), 10'h007, "mid-run reset");
        presetn <= 1'b1;
        settle();
        rd(ADDR_STATUS, {25'h0, 7'h08});
        tally_and_finish();
    end
endmodule : test_line_audio_route_relay_ctrl
